// File: pdra_top.sv
/*
  Register access channel carried in cyclic process data: control byte plus
  output word in, status byte plus input word out, 64 registers.
  Assumes process data bytes are synchronous to clk and held stable between
  cycles; rst_n stands in for a power cycle.
*/
// What this block does
// - Control bit 7 set selects register communication instead of process data.
// - Bit 6 set with bit 7 requests writing the output word.
// - Bit 6 clear with bit 7 requests reading the addressed register.
// - Bits 5..0 give the register number, 64 registers.
// - Read acknowledge returns status byte equal to control byte.
// - Write acknowledge returns control byte with bit 6 cleared.
// - Read places register value in input word, high byte first.
// - Write takes output word, byte 1 high, byte 2 low.
// - Output word is ignored during reads.
// - Normally user registers reject writes, except register 31.
// - Writing 0x1235 to register 31 lifts write protection.
// - Any other value in register 31 restores write protection.
// - Reading register 31 returns the last written code word.
// - Register 32 holds feature bits; reads back at once; the active copy loads it after reset, which has already cleared it to 0.
// - User register changes other than register 31 never affect behaviour, since reset clears register 32 before the active copy loads; register 31 acts at once.
`timescale 1ns/100ps
module pdra_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] control_byte,
  input wire logic [7:0] output_data_hi,
  input wire logic [7:0] output_data_lo,
  input wire logic [15:0] process_input_word,
  input wire logic [7:0] process_status_byte,
  output logic [7:0] status_byte,
  output logic [7:0] input_data_hi,
  output logic [7:0] input_data_lo,
  output logic [15:0] process_output_word,
  output logic reg_mode,
  output logic write_unlocked,
  output logic [15:0] feature_active
);

  // ---------------------------------------------------------------------
  // Decode of the control byte
  // ---------------------------------------------------------------------
  logic req_reg;
  logic req_write;
  logic [5:0] req_num;
  logic [15:0] out_word;

  assign req_reg = control_byte[pdra_pkg::CTRL_REG_MODE_BIT];
  assign req_write = control_byte[pdra_pkg::CTRL_WRITE_BIT];
  assign req_num = control_byte[pdra_pkg::CTRL_ADDR_MSB:0];
  // byte 1 high, byte 2 low
  assign out_word = {output_data_hi, output_data_lo};

  // ---------------------------------------------------------------------
  // Change detection and state
  // ---------------------------------------------------------------------
  logic [7:0] last_ctrl;
  logic [7:0] next_last_ctrl;
  logic seen;
  logic next_seen;
  pdra_pkg::pdra_state_t state;
  pdra_pkg::pdra_state_t next_state;
  logic ctrl_new;
  logic do_write;

  // Process data repeats every cycle, so a held write byte
  // must not write again; first cycle after reset counts as new
  // new request only on changed byte
  assign ctrl_new = !seen || (control_byte != last_ctrl);
  assign do_write = req_reg && req_write && ctrl_new;

  // Track last control byte and exchange kind
  always_comb begin
    next_last_ctrl = control_byte;
    next_seen = 1'b1;
    next_state = state;
    unique case (state)
      pdra_pkg::PDRA_IDLE,
      pdra_pkg::PDRA_READ,
      pdra_pkg::PDRA_WRITE: begin
        if (!req_reg) begin
          next_state = pdra_pkg::PDRA_IDLE;
        end else if (req_write) begin
          next_state = pdra_pkg::PDRA_WRITE;
        end else begin
          next_state = pdra_pkg::PDRA_READ;
        end
      end
      default: begin
        next_state = pdra_pkg::PDRA_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_ctrl <= 8'h00;
      seen <= 1'b0;
      state <= pdra_pkg::PDRA_IDLE;
    end else begin
      last_ctrl <= next_last_ctrl;
      seen <= next_seen;
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [15:0] reg_value [pdra_pkg::REG_COUNT];
  logic [pdra_pkg::REG_COUNT-1:0] wr_strobe;
  logic unlocked;

  // Compared on the stored word, so a relock acts at once
  // unlock when code matches
  assign unlocked = (reg_value[pdra_pkg::REG_WRITE_UNLOCK_CODE] == pdra_pkg::UNLOCK_VALUE);
  assign write_unlocked = unlocked;

  // Write strobes per register
  always_comb begin
    wr_strobe = '0;
    if (do_write) begin
      if (req_num == pdra_pkg::REG_WRITE_UNLOCK_CODE) begin
        wr_strobe[req_num] = 1'b1;
      end else if (req_num < pdra_pkg::REG_USER_FIRST || unlocked) begin
        wr_strobe[req_num] = 1'b1;
      end
    end
  end

  // One cell per register
  genvar gi;
  generate
    for (gi = 0; gi < pdra_pkg::REG_COUNT; gi++) begin : g_reg
      pdra_word_reg #(
        .RESET_VALUE(pdra_pkg::REG_RESET)
      ) u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_strobe[gi]),
        .wr_data(out_word),
        .value(reg_value[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Restart-effective copy of the feature register
  // ---------------------------------------------------------------------
  logic restart_load;
  logic next_restart_load;
  logic boot_done;
  logic next_boot_done;

  // Reset stands for power-up: the running copy moves only here,
  // never on a register write
  // One load pulse after reset release
  always_comb begin
    next_boot_done = 1'b1;
    next_restart_load = !boot_done;
  end

  // Boot sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_done <= 1'b0;
      restart_load <= 1'b0;
    end else begin
      boot_done <= next_boot_done;
      restart_load <= next_restart_load;
    end
  end

  pdra_active_latch u_feature_active (
    .clk(clk),
    .rst_n(rst_n),
    .restart_load(restart_load),
    .stored(reg_value[pdra_pkg::REG_FEATURE_CONFIG]),
    .active(feature_active)
  );

  // ---------------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------------
  logic [7:0] next_status;
  logic [15:0] next_in_word;
  logic [15:0] in_word;

  // Write ack keeps the old input word; the controller drops it
  // Status byte and input word
  always_comb begin
    next_status = process_status_byte;
    next_in_word = process_input_word;
    if (req_reg) begin
      if (req_write) begin
        next_status = control_byte & 8'hbf;
        next_in_word = in_word;
      end else begin
        next_status = control_byte;
        next_in_word = reg_value[req_num];
      end
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_byte <= pdra_pkg::STATUS_RESET;
      in_word <= pdra_pkg::INPUT_WORD_RESET;
      process_output_word <= 16'h0000;
    end else begin
      status_byte <= next_status;
      in_word <= next_in_word;
      process_output_word <= req_reg ? process_output_word : out_word;
    end
  end

  assign input_data_hi = in_word[15:8];
  assign input_data_lo = in_word[7:0];

  assign reg_mode = (state != pdra_pkg::PDRA_IDLE);

endmodule

// File: pdra_pkg.sv
/*
  Package for the process data register access block: control byte fields,
  register numbers, unlock code and reset values.
  Assumes a single 100 MHz clock domain and synchronous active-low reset.
*/
package pdra_pkg;

  // ---------------------------------------------------------------------
  // Control and status byte layout
  // ---------------------------------------------------------------------
  localparam int unsigned CTRL_REG_MODE_BIT = 7;
  localparam int unsigned CTRL_WRITE_BIT = 6;
  localparam int unsigned CTRL_ADDR_MSB = 5;
  localparam int unsigned REG_NUM_W = 6;
  localparam int unsigned REG_COUNT = 64;
  localparam int unsigned WORD_W = 16;

  // ---------------------------------------------------------------------
  // Register numbers and values
  // ---------------------------------------------------------------------
  localparam logic [5:0] REG_WRITE_UNLOCK_CODE = 6'h1f;
  localparam logic [5:0] REG_FEATURE_CONFIG = 6'h20;
  localparam logic [5:0] REG_USER_FIRST = 6'h1f;
  localparam logic [15:0] UNLOCK_VALUE = 16'h1235;
  localparam logic [15:0] WRITE_UNLOCK_CODE_RESET = 16'h0000;
  localparam logic [15:0] FEATURE_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] INPUT_WORD_RESET = 16'h0000;

  // Exchange states
  typedef enum logic [2:0] {
    PDRA_IDLE = 3'b001,
    PDRA_READ = 3'b010,
    PDRA_WRITE = 3'b100
  } pdra_state_t;

endpackage

// File: pdra_word_reg.sv
/*
  One 16-bit register cell with a write strobe; used for the register file.
  Assumes the same clock and synchronous active-low reset as the top.
*/
`timescale 1ns/100ps
module pdra_word_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value
);

  logic [15:0] next_value;

  // Load on strobe
  always_comb begin
    next_value = value;
    if (wr_en) begin
      next_value = wr_data;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

endmodule

// File: pdra_active_latch.sv
/*
  Holds the "active" copy of a register, taken only at a restart strobe.
  Assumes restart_load pulses once after reset release.
*/
`timescale 1ns/100ps
module pdra_active_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart_load,
  input wire logic [15:0] stored,
  output logic [15:0] active
);

  logic [15:0] next_active;

  // Take stored value only at restart
  always_comb begin
    next_active = active;
    if (restart_load) begin
      next_active = stored;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active <= pdra_pkg::FEATURE_CONFIG_RESET;
    end else begin
      active <= next_active;
    end
  end

endmodule

// File: pdra_chk.sv
/*
  Port checker for pdra_top, bound to every instance.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module pdra_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] control_byte,
  input wire logic [7:0] output_data_hi,
  input wire logic [7:0] output_data_lo,
  input wire logic [15:0] process_input_word,
  input wire logic [7:0] process_status_byte,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] input_data_hi,
  input wire logic [7:0] input_data_lo,
  input wire logic [15:0] process_output_word,
  input wire logic reg_mode,
  input wire logic write_unlocked,
  input wire logic [15:0] feature_active
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_echo: assert property (
    $past(rst_n) && $past(control_byte[7])
    |-> status_byte == ($past(control_byte) & 8'hbf)) else $error("ack byte wrong");
  a_pass_thru: assert property (
    $past(rst_n) && !$past(control_byte[7]) |-> status_byte == $past(process_status_byte)
    && {input_data_hi, input_data_lo} == $past(process_input_word)) else $error("pass bad");
  a_out_pass: assert property (
    $past(rst_n) && !$past(control_byte[7])
    |-> process_output_word == $past({output_data_hi, output_data_lo})) else $error("out bad");
  a_out_hold: assert property (
    $past(rst_n) && $past(control_byte[7]) |-> $stable(process_output_word))
    else $error("out word moved");
  a_mode_flag: assert property (
    $past(rst_n) |-> reg_mode == $past(control_byte[7])) else $error("mode flag wrong");
  a_unlock_set: assert property (
    $past(rst_n) && $past(control_byte) == 8'hdf && $past(control_byte) != $past(control_byte, 2)
    && $past({output_data_hi, output_data_lo}) == 16'h1235 |-> write_unlocked)
    else $error("no unlock");
  a_lock_back: assert property (
    $past(rst_n) && $past(control_byte) == 8'hdf && $past(control_byte) != $past(control_byte, 2)
    && $past({output_data_hi, output_data_lo}) != 16'h1235 |-> !write_unlocked)
    else $error("no relock");
  a_unlock_cause: assert property (
    $past(rst_n) && $changed(write_unlocked) |-> $past(control_byte) == 8'hdf)
    else $error("unlock moved alone");
  a_feature_hold: assert property (
    $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |-> $stable(feature_active))
    else $error("feature moved");
  a_read_stable: assert property (
    $past(rst_n) && $past(rst_n, 2) && $past(control_byte[7:6]) == 2'b10
    && $past(control_byte) == $past(control_byte, 2)
    |-> $stable({input_data_hi, input_data_lo})) else $error("read word moved");
endmodule
bind pdra_top pdra_chk chk_u (.*);

// File: pdra_ctl_model.sv
/*
  Controller model: sends control byte and output word, takes the answer.
  Assumes the device answers within two clock edges.
*/
`timescale 1ns/100ps
module pdra_ctl_model (
  input wire logic clk,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] input_data_hi,
  input wire logic [7:0] input_data_lo,
  output logic [7:0] control_byte,
  output logic [7:0] output_data_hi,
  output logic [7:0] output_data_lo
);
  // ---------------------------------------------------------------
  // Exchange tasks
  // ---------------------------------------------------------------
  logic [7:0] st;
  logic [15:0] wd;
  initial begin
    control_byte = 8'h00;
    output_data_hi = 8'h00;
    output_data_lo = 8'h00;
  end
  // One exchange, answer taken once settled
  task send(input logic [7:0] cb, input logic [15:0] w);
    @(posedge clk);
    control_byte <= cb;
    output_data_hi <= w[15:8];
    output_data_lo <= w[7:0];
    repeat (2) @(posedge clk);
    #1;
    st = status_byte;
    wd = cb[6] ? 16'hxxxx : {input_data_hi, input_data_lo};
  endtask
  task wr(input logic [5:0] a, input logic [15:0] w);
    send({2'b11, a}, w);
  endtask
  task rd(input logic [5:0] a, input logic [15:0] junk);
    send({2'b10, a}, junk);
  endtask
endmodule

// File: tb_top.sv
/*
  Testbench for pdra_top: register exchanges through the controller model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
module tb_top;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] pin_w = 16'h0000;
  logic [7:0] pst = 8'h00;
  logic [7:0] cb, ohi, olo, st, ihi, ilo;
  logic [15:0] pout, feat;
  logic rmode, unl;
  int mismatches = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  pdra_top dut_u (.clk(clk), .rst_n(rst_n), .control_byte(cb), .output_data_hi(ohi),
    .output_data_lo(olo), .process_input_word(pin_w), .process_status_byte(pst),
    .status_byte(st), .input_data_hi(ihi), .input_data_lo(ilo), .process_output_word(pout),
    .reg_mode(rmode), .write_unlocked(unl), .feature_active(feat));
  pdra_ctl_model ctl_u (.clk(clk), .status_byte(st), .input_data_hi(ihi),
    .input_data_lo(ilo), .control_byte(cb), .output_data_hi(ohi), .output_data_lo(olo));
  // Compare a status byte
  task chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Compare a data word
  task chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Compare a flag
  task chk_flag(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task tally_and_finish;
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pst <= 8'h5a;
    pin_w <= 16'hc3a5;
    ctl_u.send(8'h00, 16'h6e21);
    chk_byte("status", 8'h5a, ctl_u.st);
    chk_word("in_word", 16'hc3a5, ctl_u.wd);
    chk_word("out_word", 16'h6e21, pout);
    chk_flag("reg_mode", 1'b0, rmode);
    ctl_u.wr(6'h28, 16'habcd);
    chk_byte("status", 8'ha8, ctl_u.st);
    chk_flag("reg_mode", 1'b1, rmode);
    ctl_u.rd(6'h28, 16'hffff);
    chk_word("reg40", 16'h0000, ctl_u.wd);
    chk_word("out_word", 16'h6e21, pout);
    ctl_u.wr(6'h05, 16'h1234);
    ctl_u.rd(6'h05, 16'h5555);
    chk_byte("status", 8'h85, ctl_u.st);
    chk_word("reg5", 16'h1234, ctl_u.wd);
    ctl_u.wr(6'h1f, 16'h1235);
    chk_byte("status", 8'h9f, ctl_u.st);
    chk_flag("unlocked", 1'b1, unl);
    ctl_u.rd(6'h1f, 16'h0000);
    chk_word("reg31", 16'h1235, ctl_u.wd);
    ctl_u.wr(6'h20, 16'h0002);
    chk_byte("status", 8'ha0, ctl_u.st);
    ctl_u.send(8'he0, 16'h0007);
    chk_byte("status", 8'ha0, ctl_u.st);
    ctl_u.rd(6'h20, 16'h0000);
    chk_word("reg32", 16'h0002, ctl_u.wd);
    chk_word("feature", 16'h0000, feat);
    ctl_u.wr(6'h1f, 16'h0000);
    chk_flag("unlocked", 1'b0, unl);
    ctl_u.wr(6'h20, 16'h0009);
    ctl_u.rd(6'h20, 16'h0000);
    chk_word("reg32", 16'h0002, ctl_u.wd);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ctl_u.rd(6'h1f, 16'h0000);
    chk_word("reg31", 16'h0000, ctl_u.wd);
    chk_word("feature", 16'h0000, feat);
    tally_and_finish();
  end
endmodule
